/* File: hw/order_pkg.sv */
// shared widths, op semantics and state codes for the ordering unit
// assumes one clock domain and a single in-order instruction stream
package order_pkg;
  localparam int ADDR_W = 64;
  localparam int DATA_W = 64;
  localparam int CNT_W  = 4;  // counter width; up to 15 outstanding ops per channel

  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
  localparam logic [CNT_W-1:0] CNT_MAX  = 4'hF;

  // ordering semantic attached to each access
  typedef enum logic [1:0] {
    SEM_UNORD   = 2'h0,
    SEM_ACQUIRE = 2'h1,
    SEM_RELEASE = 2'h2,
    SEM_FENCE   = 2'h3
  } sem_t;

  // one-hot issue states
  typedef enum logic [1:0] {
    ST_RUN   = 2'h1,
    ST_DRAIN = 2'h2
  } state_t;
endpackage : order_pkg

/* File: hw/uncached_sequential_ordering.sv */
// ordering unit between the memory pipeline and the two visibility channels
// assumes all ports share i_clk; acks arrive as one-cycle pulses per op
`timescale 1ns/1ps

module uncached_sequential_ordering (
  // clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_nrst,
  // request from the instruction stream
  input  wire logic                       i_op_valid,
  output logic                            o_op_ready,
  input  wire logic [1:0]                 i_op_sem,
  input  wire logic                       i_op_store,
  input  wire logic                       i_op_semaphore,
  input  wire logic                       i_uncached_attribute,
  input  wire logic                       i_uncached_exported_attribute,
  input  wire logic [order_pkg::ADDR_W-1:0] i_op_addr,
  input  wire logic [order_pkg::DATA_W-1:0] i_op_wdata,
  // coherence domain channel
  output logic                            o_coh_valid,
  input  wire logic                       i_coh_ready,
  output logic                            o_coh_store,
  output logic                            o_coh_ordered,
  output logic [order_pkg::ADDR_W-1:0]    o_coh_addr,
  output logic [order_pkg::DATA_W-1:0]    o_coh_wdata,
  input  wire logic                       i_coh_visible,
  // peripheral domain channel
  output logic                            o_per_valid,
  input  wire logic                       i_per_ready,
  output logic                            o_per_store,
  output logic [order_pkg::ADDR_W-1:0]    o_per_addr,
  output logic [order_pkg::DATA_W-1:0]    o_per_wdata,
  input  wire logic                       i_per_visible,
  // fence completion
  output logic                            o_fence_done
);

  order_pkg::state_t           state;
  order_pkg::state_t           next_state;
  logic [order_pkg::CNT_W-1:0] coh_cnt;
  logic [order_pkg::CNT_W-1:0] per_cnt;
  logic [order_pkg::CNT_W-1:0] next_coh_cnt;
  logic [order_pkg::CNT_W-1:0] next_per_cnt;
  logic                        fence_pend;

  // request decode
  wire op_seq     = i_uncached_attribute | i_uncached_exported_attribute;
  wire op_fence   = (i_op_sem == order_pkg::SEM_FENCE);
  wire op_release = (i_op_sem == order_pkg::SEM_RELEASE);
  wire op_acquire = (i_op_sem == order_pkg::SEM_ACQUIRE);
  wire op_ordered = op_release | i_op_semaphore;
  wire coh_idle   = (coh_cnt == order_pkg::CNT_ZERO);
  wire per_idle   = (per_cnt == order_pkg::CNT_ZERO);
  wire coh_free   = (!o_coh_valid || i_coh_ready) && (coh_cnt != order_pkg::CNT_MAX);
  wire per_free   = (!o_per_valid || i_per_ready) && (per_cnt != order_pkg::CNT_MAX);
  // sequential ops go through the one in-order peripheral slot whatever the
  // semantic, so weaker semantics cannot reorder them
  wire seq_ok     = per_free && (!op_release || coh_idle);
  // ordered cacheable ops issue only with no earlier cacheable op in flight, which
  // serialises them into one global order at the cost of throughput
  wire coh_ok     = coh_free && (!op_ordered || coh_idle);
  wire run        = (state == order_pkg::ST_RUN);
  // unordered cacheable ops are not held for each other
  assign o_op_ready = run && (op_fence || (op_seq ? seq_ok : coh_ok));
  wire take       = i_op_valid && o_op_ready;
  wire take_seq   = take && !op_fence && op_seq;
  wire take_coh   = take && !op_fence && !op_seq;
  wire drained    = coh_idle && per_idle;
  wire take_fence = take && op_fence;
  // acquires drain too: cheaper than tracking which later ops they guard
  wire enter_drain = take && (op_fence || op_acquire);
  wire drain_done  = (state == order_pkg::ST_DRAIN) && drained;
  // interruption entry has no input here: in-flight ops keep draining as usual

  // counters of issued but not yet visible ops
  assign next_coh_cnt = coh_cnt + (take_coh ? order_pkg::CNT_ONE : order_pkg::CNT_ZERO)
                        - (i_coh_visible ? order_pkg::CNT_ONE : order_pkg::CNT_ZERO);
  assign next_per_cnt = per_cnt + (take_seq ? order_pkg::CNT_ONE : order_pkg::CNT_ZERO)
                        - (i_per_visible ? order_pkg::CNT_ONE : order_pkg::CNT_ZERO);

  // fences and acquires stop later issue until everything drained
  always_comb begin
    case (state)
      order_pkg::ST_RUN:   next_state = enter_drain
                                        ? order_pkg::ST_DRAIN : order_pkg::ST_RUN;
      order_pkg::ST_DRAIN: next_state = drained ? order_pkg::ST_RUN : order_pkg::ST_DRAIN;
      default:             next_state = order_pkg::ST_RUN;
    endcase
  end

  // state, counters and fence completion
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state        <= order_pkg::ST_RUN;
      coh_cnt      <= order_pkg::CNT_ZERO;
      per_cnt      <= order_pkg::CNT_ZERO;
      fence_pend   <= 1'h0;
      o_fence_done <= 1'h0;
    end else begin
      state        <= next_state;
      coh_cnt      <= next_coh_cnt;
      per_cnt      <= next_per_cnt;
      fence_pend   <= take_fence || (fence_pend && !drain_done);
      o_fence_done <= fence_pend && drain_done;
    end
  end

  // coherence output slot, held until taken
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_coh_valid   <= 1'h0;
      o_coh_store   <= 1'h0;
      o_coh_ordered <= 1'h0;
      o_coh_addr    <= '0;
      o_coh_wdata   <= '0;
    end else if (take_coh) begin
      o_coh_valid   <= 1'h1;
      o_coh_store   <= i_op_store;
      o_coh_ordered <= op_ordered;
      o_coh_addr    <= i_op_addr;
      o_coh_wdata   <= i_op_wdata;
    end else if (i_coh_ready) begin
      o_coh_valid   <= 1'h0;
    end
  end

  // peripheral output slot; single slot keeps program order, and nothing is
  // copied toward other observers
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_per_valid <= 1'h0;
      o_per_store <= 1'h0;
      o_per_addr  <= '0;
      o_per_wdata <= '0;
    end else if (take_seq) begin
      o_per_valid <= 1'h1;
      o_per_store <= i_op_store;
      o_per_addr  <= i_op_addr;
      o_per_wdata <= i_op_wdata;
    end else if (i_per_ready) begin
      o_per_valid <= 1'h0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  // named steps: a stalled slot, a blocked sequential op, a fence, a drain
  sequence s_per_stalled;
    o_per_valid && !i_per_ready;
  endsequence

  sequence s_coh_stalled;
    o_coh_valid && !i_coh_ready;
  endsequence

  sequence s_seq_blocked;
    i_op_valid && op_seq && !op_fence && !per_free;
  endsequence

  sequence s_fence_taken;
    take_fence;
  endsequence

  sequence s_drain_seen;
    drain_done;
  endsequence

  // a taken op must appear whole on its slot one cycle later
  property p_per_capture;
    take_seq |=> o_per_valid && o_per_addr == $past(i_op_addr)
                 && o_per_wdata == $past(i_op_wdata) && o_per_store == $past(i_op_store);
  endproperty

  property p_coh_capture;
    take_coh |=> o_coh_valid && o_coh_addr == $past(i_op_addr)
                 && o_coh_wdata == $past(i_op_wdata) && o_coh_store == $past(i_op_store);
  endproperty

  // a stalled slot keeps its op untouched, which is what keeps program order
  property p_per_hold;
    s_per_stalled |=> o_per_valid && $stable(o_per_addr) && $stable(o_per_wdata);
  endproperty

  property p_coh_hold;
    s_coh_stalled |=> o_coh_valid && $stable(o_coh_addr) && $stable(o_coh_wdata);
  endproperty

  // an ordered op leaves with nothing of its own ahead of it
  property p_ordered_alone;
    take_coh && op_ordered |=> o_coh_ordered && coh_cnt == order_pkg::CNT_ONE;
  endproperty

  // peripheral slot
  a_uc_to_periph: assert property (p_per_capture)
    else $error("sequential op not placed on peripheral channel");
  a_per_slot_hold: assert property (p_per_hold)
    else $error("peripheral op dropped or changed while stalled");
  a_seq_any_sem: assert property (s_seq_blocked |-> !o_op_ready)
    else $error("sequential op passed a pending peripheral op");
  a_seq_not_shared: assert property (take_seq && !o_coh_valid |=> !o_coh_valid)
    else $error("sequential op leaked onto coherence channel");
  a_release_hold: assert property (take_seq && op_release |-> coh_idle)
    else $error("sequential release issued before cacheable visibility");

  // coherence slot
  a_coh_capture: assert property (p_coh_capture)
    else $error("cacheable op not placed on coherence channel");
  a_coh_slot_hold: assert property (p_coh_hold)
    else $error("coherence op dropped or changed while stalled");
  a_ordered_total: assert property (p_ordered_alone)
    else $error("ordered cacheable op issued with earlier ops in flight");

  // issue state and fences
  a_run_no_drain: assert property (run && !enter_drain |=> run)
    else $error("issue stalled without a fence or acquire");
  a_drain_blocks: assert property (!run |-> !o_op_ready)
    else $error("op accepted while draining");
  a_fence_drain: assert property (o_fence_done |-> $past(drained))
    else $error("fence completed with ops outstanding");
  a_fence_blocks: assert property (s_fence_taken |=> !o_op_ready && !run)
    else $error("later op accepted behind an open fence");
  a_fence_done_time: assert property (s_fence_taken ##1 s_drain_seen |=> o_fence_done)
    else $error("fence completion not signalled after drain");
  a_fence_pulse: assert property (o_fence_done |=> !o_fence_done)
    else $error("fence completion held longer than one cycle");

endmodule : uncached_sequential_ordering

/* File: bench/far_side_model.sv */
// far side of one visibility channel: takes ops, later pulses visible once per op
// assumes one clock with the unit; visible never pulses with nothing pending
`timescale 1ns/1ps
module far_side_model #(
  parameter int SEED = 32'h1234
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_nrst,
  // op channel from the unit, and the stall switch from the bench
  input  wire logic i_valid,
  input  wire logic i_stall,
  output logic      o_ready,
  output logic      o_visible
);
  int pending;
  int avail;
  integer seed = SEED;
  // one agent per channel, so interleaving is never ours to settle
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      pending <= 0;
      o_ready <= 1'b0;
      o_visible <= 1'b0;
    end else begin
      avail = pending + int'(i_valid && o_ready) - int'(o_visible);
      // slow mode grants ready rarely, to stall the unit
      o_ready <= i_stall ? (($random(seed) & 7) == 0) : $random(seed) & 1;
      o_visible <= (avail > 0) && ($random(seed) & 1);
      pending <= avail;
    end
  end
endmodule : far_side_model

/* File: bench/tb_uncached_sequential_ordering.sv */
// self-checking bench: random op stream against queue-based ordering model
// assumes two far_side_model instances stand for coherence and peripheral sides
`timescale 1ns/1ps
module tb_uncached_sequential_ordering;
  logic i_clk = 1'b0, i_nrst = 1'b0, i_op_valid = 1'b0, i_op_store = 1'b0;
  logic i_op_semaphore = 1'b0, i_uncached_attribute = 1'b0;
  logic i_uncached_exported_attribute = 1'b0, stall = 1'b0;
  logic [1:0] i_op_sem = 2'h0;
  logic [63:0] i_op_addr = 64'h0, i_op_wdata = 64'h0;
  logic [127:0] coh_q[$], per_q[$], got;
  logic ord;
  logic o_op_ready, o_coh_valid, i_coh_ready, o_coh_store, o_coh_ordered, i_coh_visible;
  logic o_per_valid, i_per_ready, o_per_store, i_per_visible, o_fence_done, seq;
  logic [63:0] o_coh_addr, o_coh_wdata, o_per_addr, o_per_wdata;
  int failures = 0, samples_checked = 0, coh_iss = 0, per_iss = 0, fen_iss = 0, fen_seen = 0;
  int cycles = 0;
  integer seed = 32'heb0f;
  logic [31:0] r;
  always #10 i_clk = ~i_clk;
  uncached_sequential_ordering uncached_sequential_ordering_inst (.*);
  far_side_model #(.SEED(32'h0101)) coh_side (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_valid(o_coh_valid), .i_stall(stall), .o_ready(i_coh_ready), .o_visible(i_coh_visible));
  far_side_model #(.SEED(32'h0202)) per_side (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_valid(o_per_valid), .i_stall(stall), .o_ready(i_per_ready), .o_visible(i_per_visible));
  task check(input string name, input logic [127:0] exp, input logic [127:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task close_out;
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // model: program order per channel, outstanding counts from issue to visible
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      close_out();
    end else if (!i_nrst) begin
      // outputs are unknown until the first reset edge has been taken
      got = {o_coh_valid, o_per_valid, o_fence_done};
      if (cycles > 1) check("reset_out", 128'h0, got);
    end else begin
      // fence looks at the counts left before this edge's own issue
      if (o_fence_done === 1'b1) begin
        fen_seen++;
        check("fence_drain", 128'h0, {coh_iss, per_iss});
      end
      seq = i_uncached_attribute | i_uncached_exported_attribute;
      if (i_op_valid && o_op_ready && i_op_sem == 2'h3) fen_iss++;
      else if (i_op_valid && o_op_ready && seq) begin
        if (i_op_sem == 2'h2) check("rel_wait", 128'h0, coh_iss - i_coh_visible);
        per_q.push_back({i_op_wdata, i_op_addr[62:0], i_op_store});
        per_iss++;
      end else if (i_op_valid && o_op_ready) begin
        ord = (i_op_sem == 2'h2) || i_op_semaphore;
        if (ord) check("tot_wait", 128'h0, coh_iss - i_coh_visible);
        coh_q.push_back({i_op_wdata, i_op_addr[61:0], ord, i_op_store});
        coh_iss++;
      end
      got = {o_per_wdata, o_per_addr[62:0], o_per_store};
      if (o_per_valid && i_per_ready) check("per_op", per_q.pop_front(), got);
      got = {o_coh_wdata, o_coh_addr[61:0], o_coh_ordered, o_coh_store};
      if (o_coh_valid && i_coh_ready) check("coh_op", coh_q.pop_front(), got);
      coh_iss -= int'(i_coh_visible);
      per_iss -= int'(i_per_visible);
    end
  end
  // holds the request until ready is seen high at a falling edge, then through the next rising edge
  task issue(input logic [31:0] v);
    i_op_valid <= 1'b1;
    i_op_sem <= v[1:0];
    i_op_store <= v[2];
    i_op_semaphore <= v[3] && v[1:0] != 2'h3;
    i_uncached_attribute <= v[4] && v[1:0] != 2'h3;
    i_uncached_exported_attribute <= v[5] && v[1:0] != 2'h3;
    i_op_addr <= {v, $random(seed)};
    i_op_wdata <= {$random(seed), v};
    do @(negedge i_clk); while (o_op_ready !== 1'b1);
    @(posedge i_clk);
  endtask : issue
  initial begin
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    for (int k = 0; k < 400; k++) begin
      r = $random(seed);
      stall <= (k > 250 && k < 300);
      issue(r);
    end
    issue(32'h3); // final fence before any context change
    i_op_valid <= 1'b0;
    repeat (200) @(posedge i_clk);
    check("fences", fen_iss, fen_seen);
    check("drained", 64'h0, coh_q.size() + per_q.size());
    close_out();
  end
endmodule : tb_uncached_sequential_ordering
